// ### design/led_power_ctrl.sv
// LED driver power states, pump gain control, drive levels and PWM.
// Assumes synchronous pins, a one-cycle 32 kHz strobe and a host on
// the two-wire register port.
// Function
// - Writing FFH to register 0DH returns every register to its default.
// - After power-on reset the chip enters standby with chip-on cleared.
// - Chip-on bit or enable pin low keeps the chip in standby, all off.
// - Standby accepts writes other than the 0DH reset key only with enable high; they act after startup.
// - Chip-on high with enable high runs a 500 us startup, then normal.
// - Thermal trip disables operation and holds startup until it clears.
// - Enable pin low in normal operation clears the chip-on bit.
// - Power save turns analog blocks off and keeps register contents.
// - Config bits 4:3 pick pump gain: off, 1x, 1.5x or automatic.
// - Gain select 00b disables the pump and pulls its output down.
// - Automatic gain uses 1.5x when a monitored driver lacks headroom.
// - Automatic gain falls back to 1x after over 50 ms of inactivity.
// - Headroom decisions are filtered so short disturbances change nothing.
// - Red supply bit routes red to battery and drops its monitoring.
// - Green and blue always run from the pump output.
// - Each 8-bit current register sets 0.1 mA steps, default AFh.
// - Each output is pulse-width modulated by an 8-bit duty value.
// - Config bit 6 selects 256 Hz or 558 Hz PWM rate.
// - Enable register bit 7 selects linear or logarithmic brightness.
module led_power_ctrl #(
	parameter int STARTUP_CYC = led_pwr_pkg::STARTUP_CYC,
	parameter int FILT_CYC = led_pwr_pkg::FILT_CYC
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Register port
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	// Chip inputs
	input wire logic EN,
	input wire logic THERMAL_TRIP,
	input wire logic SLOW_TIMEBASE,
	input wire logic [2:0] HEADROOM_LOW,
	// Duty values per channel
	input wire logic [7:0] DUTY_R,
	input wire logic [7:0] DUTY_G,
	input wire logic [7:0] DUTY_B,
	// Pump and analog control
	output logic ANALOG_ON,
	output logic PUMP_ON,
	output logic PUMP_HIGH_GAIN,
	output logic PUMP_PULLDOWN,
	output logic RED_FROM_BATT,
	// Drivers
	output logic [2:0] LED_PWM,
	output logic [7:0] LEVEL_R,
	output logic [7:0] LEVEL_G,
	output logic [7:0] LEVEL_B
);
	localparam int SW = $clog2(STARTUP_CYC + 1);
	localparam int FW = $clog2(FILT_CYC + 1);
	localparam int DW = $clog2(led_pwr_pkg::PWM_LO_DIV + 1);

	typedef enum logic [2:0] {
		P_RESET, P_STANDBY, P_STARTUP, P_NORMAL, P_SAVE
	} pwr_e;

	pwr_e pst_q, pst_d;
	logic [SW-1:0] stup_q, stup_d;
	logic [7:0] en_q, cfg_q;
	logic [7:0] cur_q [3];
	logic [7:0] duty [3];
	logic wr_stb;
	logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
	logic filt_q, slow_q, analog_q, pump_q, hi_q, pull_q, red_q;
	logic [FW-1:0] flt_q;
	logic [10:0] idle_q;
	logic [DW-1:0] step_q;
	logic [7:0] pcnt_q;
	logic [2:0] pwm_q, act_req;
	logic [7:0] lvl_q [3];

	serial_reg_port u_port (
		.clk(MCLK),
		.rst_n(RST_N),
		.scl(SCL),
		.sda_in(SDA_IN),
		.sda_out(SDA_OUT),
		.sda_oe(SDA_OE),
		.wr_stb(wr_stb),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	// Register decode
	wire soft_rst = wr_stb && wr_addr == led_pwr_pkg::ADDR_RESET &&
		wr_data == led_pwr_pkg::RESET_KEY;
	wire wr_ok = wr_stb && (pst_q != P_STANDBY || EN);
	wire we_en = wr_ok && wr_addr == led_pwr_pkg::ADDR_ENABLE;
	wire we_cfg = wr_ok && wr_addr == led_pwr_pkg::ADDR_CONFIG;
	wire [7:0] cur_idx = rd_addr - led_pwr_pkg::ADDR_CUR_R;
	wire rd_cur = rd_addr >= led_pwr_pkg::ADDR_CUR_R && cur_idx < 8'h03;
	assign rd_data = rd_addr == led_pwr_pkg::ADDR_ENABLE ? en_q :
		rd_addr == led_pwr_pkg::ADDR_CONFIG ? cfg_q :
		rd_cur ? cur_q[cur_idx[1:0]] : 8'h00;
	wire chip_on = en_q[led_pwr_pkg::EN_CHIP_BIT];
	wire chip_req = chip_on && EN;
	wire run = pst_q == P_NORMAL;
	wire [1:0] gain = cfg_q[led_pwr_pkg::CFG_GAIN_HI:led_pwr_pkg::CFG_GAIN_LO];
	wire red_batt = cfg_q[led_pwr_pkg::CFG_RED_BIT];
	wire log_on = en_q[led_pwr_pkg::EN_LOG_BIT];
	wire slow_tick = SLOW_TIMEBASE && !slow_q;
	wire idle_long = idle_q > 11'(led_pwr_pkg::IDLE_TICKS);
	wire save_ok = cfg_q[led_pwr_pkg::CFG_SAVE_BIT] && idle_long &&
		act_req == 3'h0;
	// Green and blue are always monitored since they sit on the pump
	wire [2:0] mon_mask = {2'h3, !red_batt};
	wire mon_low = |(HEADROOM_LOW & mon_mask);
	wire [DW-1:0] step_div = cfg_q[led_pwr_pkg::CFG_RATE_BIT] ?
		DW'(led_pwr_pkg::PWM_HI_DIV - 1) :
		DW'(led_pwr_pkg::PWM_LO_DIV - 1);
	wire step_end = step_q == step_div;

	assign duty[0] = DUTY_R;
	assign duty[1] = DUTY_G;
	assign duty[2] = DUTY_B;
	assign LEVEL_R = lvl_q[0];
	assign LEVEL_G = lvl_q[1];
	assign LEVEL_B = lvl_q[2];
	assign LED_PWM = pwm_q;
	assign ANALOG_ON = analog_q;
	assign PUMP_ON = pump_q;
	assign PUMP_HIGH_GAIN = hi_q;
	assign PUMP_PULLDOWN = pull_q;
	assign RED_FROM_BATT = red_q;

	// Logarithmic brightness: 3-bit exponent, 5-bit mantissa
	function automatic logic [7:0] log_map(input logic [7:0] d);
		logic [13:0] m;
		m = 14'({1'b1, d[4:0]}) << d[7:5];
		log_map = (d == 8'h00) ? 8'h00 : m[12:5];
	endfunction : log_map

	// Control registers
	always_ff @(posedge MCLK) begin
		if (!RST_N || soft_rst) begin
			en_q <= led_pwr_pkg::ENABLE_RST;
			cfg_q <= led_pwr_pkg::CONFIG_RST;
		end else begin
			if (we_en)
				en_q <= wr_data;
			if (we_cfg)
				cfg_q <= wr_data;
			// Pin low beats a same-cycle software set
			if ((run || pst_q == P_SAVE) && !EN)
				en_q[led_pwr_pkg::EN_CHIP_BIT] <= 1'b0;
		end
	end

	// Power state sequencing
	always_comb begin
		pst_d = pst_q;
		stup_d = stup_q;
		case (pst_q)
			P_RESET: pst_d = P_STANDBY;
			P_STANDBY: begin
				stup_d = '0;
				if (chip_req)
					pst_d = P_STARTUP;
			end
			P_STARTUP: begin
				if (!chip_req)
					pst_d = P_STANDBY;
				else if (THERMAL_TRIP)
					stup_d = '0;
				else if (stup_q == SW'(STARTUP_CYC - 1))
					pst_d = P_NORMAL;
				else
					stup_d = stup_q + SW'(1);
			end
			P_NORMAL, P_SAVE: begin
				stup_d = '0;
				if (!chip_req)
					pst_d = P_STANDBY;
				else if (THERMAL_TRIP)
					pst_d = P_STARTUP;
				else
					pst_d = save_ok ? P_SAVE : P_NORMAL;
			end
			default: pst_d = P_RESET;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N || soft_rst) begin
			pst_q <= P_RESET;
			stup_q <= '0;
		end else begin
			pst_q <= pst_d;
			stup_q <= stup_d;
		end
	end

	// Headroom filter: a new decision must persist FILT_CYC cycles
	always_ff @(posedge MCLK) begin
		if (!RST_N || soft_rst) begin
			filt_q <= 1'b0;
			flt_q <= '0;
		end else if (mon_low == filt_q) begin
			flt_q <= '0;
		end else if (flt_q == FW'(FILT_CYC - 1)) begin
			filt_q <= mon_low;
			flt_q <= '0;
		end else begin
			flt_q <= flt_q + FW'(1);
		end
	end

	// Idle time on slow ticks, saturating just past the limit
	always_ff @(posedge MCLK) begin
		slow_q <= RST_N && SLOW_TIMEBASE;
		if (!RST_N || soft_rst || pwm_q != 3'h0)
			idle_q <= 11'h000;
		else if (slow_tick && !idle_long)
			idle_q <= idle_q + 11'h001;
	end

	// Pump and analog outputs; standby settings act only once running
	always_ff @(posedge MCLK) begin
		if (!RST_N || soft_rst) begin
			analog_q <= 1'b0;
			pump_q <= 1'b0;
			hi_q <= 1'b0;
			pull_q <= 1'b1;
			red_q <= 1'b0;
		end else begin
			analog_q <= pst_q == P_STARTUP || run;
			pump_q <= run && gain != led_pwr_pkg::GAIN_OFF;
			pull_q <= !run || gain == led_pwr_pkg::GAIN_OFF;
			hi_q <= run && (gain == led_pwr_pkg::GAIN_15X ||
				(gain == led_pwr_pkg::GAIN_AUTO && filt_q &&
				!idle_long));
			red_q <= red_batt && (run || pst_q == P_SAVE);
		end
	end

	// PWM timebase
	always_ff @(posedge MCLK) begin
		if (!RST_N || soft_rst || !run) begin
			step_q <= '0;
			pcnt_q <= 8'h00;
		end else if (step_end) begin
			step_q <= '0;
			pcnt_q <= pcnt_q + 8'h01;
		end else begin
			step_q <= step_q + DW'(1);
		end
	end

	// Per-channel current and PWM
	for (genvar i = 0; i < 3; i++) begin : g_ch
		wire we_cur = wr_ok && wr_addr == 8'(led_pwr_pkg::ADDR_CUR_R + i);
		wire [7:0] eff = log_on ? log_map(duty[i]) : duty[i];
		assign act_req[i] = duty[i] != 8'h00 && cur_q[i] != 8'h00;
		always_ff @(posedge MCLK) begin
			if (!RST_N || soft_rst) begin
				cur_q[i] <= led_pwr_pkg::CUR_RST;
				lvl_q[i] <= 8'h00;
				pwm_q[i] <= 1'b0;
			end else begin
				if (we_cur)
					cur_q[i] <= wr_data;
				lvl_q[i] <= run ? cur_q[i] : 8'h00;
				pwm_q[i] <= run && cur_q[i] != 8'h00 &&
					pcnt_q < eff;
			end
		end
	end

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);

	sequence s_enter_save;
		pst_q == P_NORMAL ##1 pst_q == P_SAVE;
	endsequence

	a_soft_reset_regs: assert property (
		soft_rst |=> cur_q[0] == led_pwr_pkg::CUR_RST && pst_q == P_RESET
		&& !chip_on) else $error("soft reset did not restore defaults");
	a_reset_to_standby: assert property (
		pst_q == P_RESET |=> pst_q == P_STANDBY && !chip_on)
		else $error("reset did not go to standby");
	a_standby_all_off: assert property (
		pst_q == P_STANDBY [*2] |-> !analog_q && !pump_q &&
		lvl_q[0] == 8'h00) else $error("standby left functions on");
	a_standby_write_block: assert property (
		pst_q == P_STANDBY && !EN && wr_stb && !soft_rst |=>
		$stable(cfg_q) && $stable(cur_q[1]))
		else $error("write accepted in standby with pin low");
	a_startup_length: assert property (
		pst_q == P_NORMAL && $past(pst_q) == P_STARTUP |->
		$past(stup_q) == SW'(STARTUP_CYC - 1))
		else $error("startup length wrong");
	a_thermal_hold: assert property (
		THERMAL_TRIP && pst_q != P_STANDBY && pst_q != P_RESET &&
		!soft_rst |=> pst_q == P_STARTUP || pst_q == P_STANDBY)
		else $error("operation continued during thermal trip");
	a_pin_low_clears: assert property (
		run && !EN && !soft_rst |=> !chip_on && pst_q == P_STANDBY)
		else $error("enable pin low did not clear chip-on");
	a_save_analog_off: assert property (
		s_enter_save ##1 pst_q == P_SAVE |-> !analog_q && !pump_q)
		else $error("analog blocks on in power save");
	a_forced_gain: assert property (
		run && gain == led_pwr_pkg::GAIN_15X && !soft_rst |=> hi_q)
		else $error("forced 1.5x gain not applied");
	a_pump_off_pull: assert property (
		gain == led_pwr_pkg::GAIN_OFF |=> pull_q && !pump_q)
		else $error("pump off without pulldown");
	a_auto_idle_1x: assert property (
		gain == led_pwr_pkg::GAIN_AUTO && idle_long |=> !hi_q)
		else $error("pump stayed at 1.5x while idle");
	a_filter_persist: assert property (
		$changed(filt_q) && !$past(soft_rst) |->
		$past(flt_q) == FW'(FILT_CYC - 1))
		else $error("headroom decision changed unfiltered");
	a_red_unmonitored: assert property (
		red_batt |-> mon_low == |HEADROOM_LOW[2:1])
		else $error("red still monitored on battery");
	a_zero_duty_dark: assert property (
		duty[1] == 8'h00 [*2] |-> !pwm_q[1])
		else $error("output lit with zero duty");
endmodule : led_power_ctrl

// ### design/led_pwr_pkg.sv
// Constants for the LED driver power and pump control block.
// Assumes a 200 MHz MCLK and a 32 kHz slow timebase strobe input.
package led_pwr_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_ENABLE = 8'h00;
	localparam logic [7:0] ADDR_CUR_R = 8'h05;
	localparam logic [7:0] ADDR_CONFIG = 8'h08;
	localparam logic [7:0] ADDR_RESET = 8'h0D;
	localparam logic [7:0] RESET_KEY = 8'hFF;
	// Reset values
	localparam logic [7:0] ENABLE_RST = 8'h00;
	localparam logic [7:0] CUR_RST = 8'hAF;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	// Field positions
	localparam int EN_LOG_BIT = 7;
	localparam int EN_CHIP_BIT = 6;
	localparam int CFG_RATE_BIT = 6;
	localparam int CFG_SAVE_BIT = 5;
	localparam int CFG_GAIN_HI = 4;
	localparam int CFG_GAIN_LO = 3;
	localparam int CFG_RED_BIT = 0;
	// Pump gain encodings
	localparam logic [1:0] GAIN_OFF = 2'h0;
	localparam logic [1:0] GAIN_1X = 2'h1;
	localparam logic [1:0] GAIN_15X = 2'h2;
	localparam logic [1:0] GAIN_AUTO = 2'h3;
	// Timing
	localparam int MCLK_HZ = 200_000_000;
	localparam int STARTUP_US = 500;
	localparam int STARTUP_CYC = (STARTUP_US * (MCLK_HZ / 1_000_000));
	localparam int SLOW_HZ = 32_000;
	localparam int IDLE_MS = 50;
	localparam int IDLE_TICKS = IDLE_MS * SLOW_HZ / 1000;
	localparam int PWM_LO_HZ = 256;
	localparam int PWM_HI_HZ = 558;
	localparam int PWM_STEPS = 256;
	localparam int PWM_LO_DIV = MCLK_HZ / (PWM_LO_HZ * PWM_STEPS);
	localparam int PWM_HI_DIV = MCLK_HZ / (PWM_HI_HZ * PWM_STEPS);
	localparam int FILT_CYC = 64;
	localparam logic [6:0] DEV_ADDR = 7'h32;
endpackage : led_pwr_pkg

// ### design/serial_reg_port.sv
// Two-wire serial register port: byte writes and reads, auto increment.
// Assumes SCL and SDA already synchronous to clk; SDA is open drain.
module serial_reg_port #(
	parameter logic [6:0] DEV_ADDR = led_pwr_pkg::DEV_ADDR
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Register side
	output logic wr_stb,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data
);
	typedef enum logic [2:0] {S_IDLE, S_DEV, S_REG, S_WR, S_RD} port_e;
	port_e st_q;
	logic scl_q, sda_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q, out_q;
	wire rise = scl & ~scl_q;
	wire fall = ~scl & scl_q;
	wire start = scl & scl_q & sda_q & ~sda_in;
	wire stop = scl & scl_q & ~sda_q & sda_in;
	wire byte_end = fall && cnt_q == 4'h7;
	wire ack_end = fall && cnt_q == 4'h8;

	always_ff @(posedge clk) begin
		scl_q <= scl;
		sda_q <= sda_in;
		sda_out <= 1'b0;
		wr_stb <= 1'b0;
		if (!rst_n) begin
			st_q <= S_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			out_q <= 8'h00;
			sda_oe <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
			rd_addr <= 8'h00;
		end else if (start) begin
			st_q <= S_DEV;
			// The start's own SCL fall wraps this to zero before bit 7
			cnt_q <= 4'h8;
			sda_oe <= 1'b0;
		end else if (stop) begin
			st_q <= S_IDLE;
			sda_oe <= 1'b0;
		end else if (st_q != S_IDLE) begin
			if (rise && cnt_q < 4'h8)
				sh_q <= {sh_q[6:0], sda_in};
			// Master nack ends a read
			if (rise && cnt_q == 4'h8 && st_q == S_RD && sda_in)
				st_q <= S_IDLE;
			if (fall)
				cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
			if (byte_end) begin
				case (st_q)
					S_DEV: begin
						sda_oe <= (sh_q[7:1] == DEV_ADDR);
						if (sh_q[7:1] != DEV_ADDR)
							st_q <= S_IDLE;
						else
							st_q <= sh_q[0] ? S_RD : S_REG;
					end
					S_REG: begin
						rd_addr <= sh_q;
						sda_oe <= 1'b1;
						st_q <= S_WR;
					end
					S_WR: begin
						wr_stb <= 1'b1;
						wr_addr <= rd_addr;
						wr_data <= sh_q;
						rd_addr <= rd_addr + 8'h01;
						sda_oe <= 1'b1;
					end
					S_RD: begin
						sda_oe <= 1'b0;
						rd_addr <= rd_addr + 8'h01;
					end
					default: st_q <= S_IDLE;
				endcase
			end else if (ack_end) begin
				sda_oe <= (st_q == S_RD) && !rd_data[7];
				out_q <= {rd_data[6:0], 1'b0};
			end else if (fall && st_q == S_RD) begin
				sda_oe <= !out_q[7];
				out_q <= {out_q[6:0], 1'b0};
			end
		end
	end
endmodule : serial_reg_port

// ### test/serial_host_model.sv
// Host side of the two-wire register port: master for writes and reads.
// Assumes a pulled-up open-drain data line and a synchronous clock.
module serial_host_model #(
	parameter logic [6:0] DEV_ADDR = led_pwr_pkg::DEV_ADDR
) (
	// Clock
	input wire logic clk,
	// Wire
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	timeunit 1ns;
	timeprecision 100ps;
	logic scl_q = 1'b1;
	logic low_q = 1'b0;
	// Pull-up wins unless a party pulls low, so released means high
	assign sda = !(low_q || sda_oe);
	assign scl = scl_q;

	task automatic step(input logic s, input logic l, input int n);
		scl_q <= s;
		low_q <= l;
		repeat (n) @(posedge clk);
	endtask : step

	// Data moves only while SCL is low; level sampled late in the high phase
	task automatic bit_io(input logic b, output logic v);
		step(1'b0, low_q, 2);
		step(1'b0, !b, 2);
		step(1'b1, !b, 3);
		@(negedge clk);
		v = sda;
		@(posedge clk);
	endtask : bit_io

	task automatic start();
		step(1'b0, low_q, 2);
		step(1'b0, 1'b0, 2);
		step(1'b1, 1'b0, 4);
		step(1'b1, 1'b1, 4);
	endtask : start

	task automatic stop();
		step(1'b0, low_q, 2);
		step(1'b0, 1'b1, 2);
		step(1'b1, 1'b1, 4);
		step(1'b1, 1'b0, 4);
	endtask : stop

	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic v;
		for (int i = 7; i >= 0; i--) bit_io(d[i], v);
		bit_io(1'b1, v);
		ack = !v;
	endtask : put_byte

	// Master ends every read with a nack after one byte
	task automatic get_byte(output logic [7:0] d);
		logic v;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(1'b1, v);
	endtask : get_byte

	task automatic write_reg(input logic [7:0] dev, input logic [7:0] a,
		input logic [7:0] d, output logic ok);
		logic k0, k1, k2;
		start();
		put_byte(dev, k0);
		put_byte(a, k1);
		put_byte(d, k2);
		stop();
		ok = k0 && k1 && k2;
	endtask : write_reg

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		logic k0, k1, k2;
		start();
		put_byte({DEV_ADDR, 1'b0}, k0);
		put_byte(a, k1);
		start();
		put_byte({DEV_ADDR, 1'b1}, k2);
		get_byte(d);
		stop();
		ok = k0 && k1 && k2;
	endtask : read_reg
endmodule : serial_host_model

// ### test/led_power_ctrl_tb.sv
// Self-checking bench for the LED power and pump control block.
// Assumes the host model above; short startup and filter counts.
module led_power_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic en = 1'b0;
	logic thermal_trip = 1'b0;
	logic slow_timebase = 1'b0;
	logic [2:0] headroom_low = 3'b000;
	logic [7:0] duty_r = 8'h00;
	logic [7:0] duty_g = 8'h00;
	logic [7:0] duty_b = 8'h00;
	logic scl, sda, sda_oe, analog_on, pump_on, pump_high_gain;
	logic pump_pulldown, red_from_batt;
	logic [2:0] led_pwm;
	logic [7:0] level_r, level_g, level_b;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;

	led_power_ctrl #(.STARTUP_CYC(50), .FILT_CYC(4)) u_dut (
		.MCLK(mclk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(),
		.SDA_OE(sda_oe), .EN(en), .THERMAL_TRIP(thermal_trip),
		.SLOW_TIMEBASE(slow_timebase), .HEADROOM_LOW(headroom_low),
		.DUTY_R(duty_r), .DUTY_G(duty_g), .DUTY_B(duty_b),
		.ANALOG_ON(analog_on), .PUMP_ON(pump_on),
		.PUMP_HIGH_GAIN(pump_high_gain), .PUMP_PULLDOWN(pump_pulldown),
		.RED_FROM_BATT(red_from_batt), .LED_PWM(led_pwm),
		.LEVEL_R(level_r), .LEVEL_G(level_g), .LEVEL_B(level_b));

	serial_host_model u_host (.clk(mclk), .sda_oe(sda_oe), .scl(scl),
		.sda(sda));

	initial begin
		forever #2.5 mclk = ~mclk;
	end

	task automatic results();
		if (fail_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results

	// Whole run needs about 20000 cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fail_count++;
			results();
		end
	end

	// Called just after an edge, so it sees the settled pre-edge values
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		u_host.write_reg({led_pwr_pkg::DEV_ADDR, 1'b0}, a, d, ok);
		chk(ok, 8'h01);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		u_host.read_reg(a, d, ok);
		chk(ok, 8'h01);
		chk(d, exp);
	endtask : rd

	task automatic tick(input int n);
		repeat (n) begin
			slow_timebase <= 1'b1;
			cyc(1);
			slow_timebase <= 1'b0;
			cyc(1);
		end
	endtask : tick

	initial begin
		logic ok;
		logic [7:0] cfg;
		cyc(10);
		rst_n <= 1'b1;
		cyc(4);
		chk({analog_on, pump_on, pump_pulldown}, 8'h01);
		chk(level_r, 8'h00);
		rd(8'h05, 8'hAF);
		rd(8'h06, 8'hAF);
		rd(8'h07, 8'hAF);
		rd(8'h08, 8'h00);
		rd(8'h00, 8'h00);
		rd(8'h0E, 8'h00);
		wr(8'h05, 8'h12);
		rd(8'h05, 8'hAF);
		en <= 1'b1;
		wr(8'h05, 8'h12);
		rd(8'h05, 8'h12);
		u_host.write_reg({~led_pwr_pkg::DEV_ADDR, 1'b0}, 8'h05, 8'h00, ok);
		chk(ok, 8'h00);
		wr(8'h00, 8'hC0);
		chk(analog_on, 8'h01);
		chk(level_r, 8'h00);
		cyc(45);
		chk(level_r, 8'h12);
		chk(level_g, 8'hAF);
		chk(level_b, 8'hAF);
		rd(8'h00, 8'hC0);
		thermal_trip <= 1'b1;
		cyc(60);
		chk(level_r, 8'h00);
		thermal_trip <= 1'b0;
		cyc(55);
		chk(level_r, 8'h12);
		// Every gain code with the red driver short of headroom
		for (int g = 0; g < 4; g++) begin
			headroom_low <= 3'b001;
			cfg = {2'b01, 1'b0, 2'(g), 3'b000};
			wr(8'h08, cfg);
			cyc(10);
			chk({pump_on, pump_pulldown, pump_high_gain},
				{cfg[4:3] != 2'b00, cfg[4:3] == 2'b00, cfg[4]});
			rd(8'h08, cfg);
		end
		headroom_low <= 3'b000;
		cyc(10);
		chk(pump_high_gain, 8'h00);
		wr(8'h08, 8'h19);
		headroom_low <= 3'b001;
		cyc(10);
		chk({red_from_batt, pump_high_gain}, 8'h02);
		headroom_low <= 3'b010;
		cyc(10);
		chk(pump_high_gain, 8'h01);
		headroom_low <= 3'b000;
		cyc(3);
		headroom_low <= 3'b010;
		chk(pump_high_gain, 8'h01);
		cyc(3);
		chk(pump_high_gain, 8'h01);
		tick(1600);
		cyc(10);
		chk(pump_high_gain, 8'h01);
		tick(1);
		cyc(10);
		chk(pump_high_gain, 8'h00);
		duty_g <= 8'hFF;
		// Log curve maps 10h to 1, so red stays dark once the count passes 0
		duty_r <= 8'h10;
		cyc(1500);
		chk(pump_high_gain, 8'h01);
		chk(led_pwm, 8'h02);
		duty_g <= 8'h00;
		duty_r <= 8'h00;
		wr(8'h08, 8'h38);
		tick(1602);
		cyc(10);
		chk(analog_on, 8'h00);
		rd(8'h05, 8'h12);
		duty_b <= 8'hFF;
		cyc(1500);
		chk(analog_on, 8'h01);
		en <= 1'b0;
		cyc(5);
		chk(level_r, 8'h00);
		en <= 1'b1;
		rd(8'h00, 8'h80);
		wr(8'h0D, 8'hFF);
		cyc(5);
		chk({analog_on, pump_pulldown}, 8'h01);
		rd(8'h05, 8'hAF);
		rd(8'h08, 8'h00);
		rd(8'h00, 8'h00);
		results();
	end
endmodule : led_power_ctrl_tb
